// File: hvpp_fifo.sv
// hvpp_fifo: small word FIFO between the page-latch strobe and the page buffer
// assumes a single clock; valid/ready on both sides
`timescale 1ns/10ps
module hvpp_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("hvpp_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic [AW:0]      next_wrPtr;
  logic [AW:0]      next_rdPtr;
  logic             doWr;
  logic             doRd;

  // full when pointers differ only in the wrap bit
  always_comb begin
    inReady    = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
    outValid   = wrPtr != rdPtr;
    outData    = mem[rdPtr[AW-1:0]];
    doWr       = inValid & inReady;
    doRd       = outValid & outReady;
    next_wrPtr = wrPtr + (AW+1)'(doWr);
    next_rdPtr = rdPtr + (AW+1)'(doRd);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // storage has no reset; contents matter only behind the pointers
  always_ff @(posedge core_clk) begin
    if (doWr) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

endmodule : hvpp_fifo

// File: hvpp_pkg.sv
// hvpp_pkg: shared constants for the parallel high-voltage programming port
// assumes nothing; the files that use it refer to it by hvpp_pkg::name
package hvpp_pkg;

  // action codes on the two action bits
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // command bytes
  localparam logic [7:0] CMD_NOP       = 8'h00;
  localparam logic [7:0] CMD_ERASE     = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_SIG    = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

  // entry pattern: page-latch, action bit 1, action bit 0, byte select a
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;

  // timing
  localparam int CLK_MHZ      = 50;
  localparam int ENTRY_HOLD_US = 10;
  localparam int ENTRY_HOLD_CYC = ENTRY_HOLD_US * CLK_MHZ; // least time, exact
  localparam int MIN_PULSE_NS = 250;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_DEPTH   = 2;

  // reset values
  localparam logic [7:0] RST_CMD  = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

endpackage : hvpp_pkg

// File: hvpp_port.sv
// hvpp_port: parallel high-voltage programming port, device side
// assumes the programmer drives strobes and data; hvActive is high while
// the reset pin sits at programming voltage; flash is modelled as an array
// How it works
// - load strobe rise decodes action: address, data, command or idle
// - write or output-enable strobe runs the last loaded command
// - write commands decoded: erase, flash
// - read commands decoded: fuse/lock, flash
// - ready/busy low during erase or programming, high when ready
// - data bus driven only while the synchronised output enable is low
// - byte select a picks low or high byte of address or data
// - byte select b only appears as bit 1 of the fuse read byte
// - entry pattern 0000 must be held 10 us when high voltage applied
// - leaving high voltage or reset ends programming mode
// - command and address stay loaded across operations
// - erase clears flash, eeprom unless kept, then locks; fuses stay
// - write strobe with erase command starts erase, busy low
// - loaded words gather in a page buffer, programmed together
// - low address bits pick word in page, upper bits pick page
// - write strobe after address high byte programs the latched words of the page
// - page latch with byte select a high moves data word into buffer
// - no-operation command load clears internal write state
// - flash read shows low or high byte by byte select a
`timescale 1ns/10ps
module hvpp_port #(
  parameter int PAGE_BITS  = 5,
  parameter int ADDR_BITS  = 11,
  parameter int ERASE_CYC  = 64,
  parameter int PROG_CYC   = 32,
  parameter int ENTRY_CYC  = hvpp_pkg::ENTRY_HOLD_CYC
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // mode control
  input  wire logic       hvActive,
  input  wire logic       keep_eeprom_on_erase,
  // strobes and selectors
  input  wire logic       load_strobe,
  input  wire logic       buffer_latch_strobe,
  input  wire logic       writeStrobeN,
  input  wire logic       outEnableN,
  input  wire logic       action_code_bit0,
  input  wire logic       action_code_bit1,
  input  wire logic       byte_sel_a,
  input  wire logic       byte_sel_b,
  // data bus, split three ways
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  // status
  output logic            ready_busy_out,
  output logic            progMode,
  output logic            eepromErased,
  output logic            locksCleared
);

  localparam int WORDS = 1 << ADDR_BITS;
  localparam int PWORDS = 1 << PAGE_BITS;
  localparam int CW = $clog2(ENTRY_CYC + ERASE_CYC + PROG_CYC + WORDS + 2);

  // refuse shapes that the counters and the address split cannot serve
  initial begin
    if (PAGE_BITS < 1 || PAGE_BITS > 8 || ADDR_BITS <= PAGE_BITS || ADDR_BITS > 16) begin
      $error("hvpp_port address widths not supported");
    end
    if (ENTRY_CYC < 1 || ERASE_CYC < 1 || PROG_CYC < 1) begin
      $error("hvpp_port timing counts must be positive");
    end
  end

  typedef enum {HV_OFF, HV_ENTRY, HV_IDLE, HV_ERASE, HV_LOCKS, HV_PROG} hvpp_state_t;

  // strobe synchronisers: load, page latch, write, output enable
  logic [3:0] sLevel;
  logic [3:0] sRise;
  logic [3:0] sFall;
  hvpp_sync #(.N(4)) uSync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .rawIn    ({outEnableN, writeStrobeN, buffer_latch_strobe, load_strobe}),
    .level    (sLevel),
    .rise     (sRise),
    .fall     (sFall)
  );

  // page latch words go through a FIFO into the page buffer
  localparam int FW = PAGE_BITS + 16;
  logic          fifoInReady;
  logic          fifoOutValid;
  logic [FW-1:0] fifoOut;
  logic          fifoDrain;

  hvpp_state_t      state;
  hvpp_state_t      next_state;
  logic [7:0]       cmd;
  logic [7:0]       next_cmd;
  logic [7:0]       addrLo;
  logic [7:0]       next_addrLo;
  logic [7:0]       addrHi;
  logic [7:0]       next_addrHi;
  logic [7:0]       dataLo;
  logic [7:0]       next_dataLo;
  logic [7:0]       dataHi;
  logic [7:0]       next_dataHi;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             next_rdy;
  logic             next_eeErased;
  logic             next_locks;
  logic [7:0]       next_dataOut;
  logic             next_dataOe;

  logic [15:0]      flash  [WORDS];
  logic [15:0]      pageBuf [PWORDS];
  logic [PWORDS-1:0] pageValid;
  logic [PWORDS-1:0] next_pageValid;

  logic             loadStb;
  logic             latchStb;
  logic             writeStb;
  logic [1:0]       action;
  logic [15:0]      fullAddr;
  logic [ADDR_BITS-1:0] wordAddr;
  logic [ADDR_BITS-PAGE_BITS-1:0] pageSel;

  assign loadStb  = sRise[0];
  assign latchStb = sRise[1];
  assign writeStb = sFall[2];
  assign action   = {action_code_bit1, action_code_bit0};
  assign fullAddr = {addrHi, addrLo};
  assign wordAddr = fullAddr[ADDR_BITS-1:0];
  assign pageSel  = wordAddr[ADDR_BITS-1:PAGE_BITS];

  // which command a write strobe acts on
  function automatic logic isCmd(input logic [7:0] c, input logic [7:0] want);
    isCmd = (c == want);
  endfunction : isCmd

  // page-latch pushes word-in-page plus data; stalls nothing but loses none
  assign fifoDrain = fifoOutValid && state == HV_IDLE;

  hvpp_fifo #(.WIDTH(FW), .DEPTH(8)) uFifo (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inValid  (latchStb && byte_sel_a && state == HV_IDLE && isCmd(cmd, hvpp_pkg::CMD_WR_FLASH)),
    .inReady  (fifoInReady),
    .inData   ({addrLo[PAGE_BITS-1:0], dataHi, dataLo}),
    .outValid (fifoOutValid),
    .outReady (fifoDrain),
    .outData  (fifoOut)
  );

  // main sequencer
  always_comb begin
    next_state    = state;
    next_cmd      = cmd;
    next_addrLo   = addrLo;
    next_addrHi   = addrHi;
    next_dataLo   = dataLo;
    next_dataHi   = dataHi;
    next_count    = count;
    next_eeErased = eepromErased;
    next_locks    = locksCleared;
    next_pageValid = pageValid;
    case (state)
      HV_OFF: begin
        // wait for high voltage with the entry pattern on the pins
        next_count = '0;
        if (hvActive && {buffer_latch_strobe, action, byte_sel_a} == hvpp_pkg::ENTRY_PATTERN)
          next_state = HV_ENTRY;
      end
      HV_ENTRY: begin
        // pattern must hold through the latch window
        if ({buffer_latch_strobe, action, byte_sel_a} != hvpp_pkg::ENTRY_PATTERN) begin
          next_state = HV_OFF;
        end else if (count == CW'(ENTRY_CYC - 1)) begin
          next_state = HV_IDLE;
          next_cmd   = hvpp_pkg::RST_CMD;
        end else begin
          next_count = count + CW'(1);
        end
      end
      HV_IDLE: begin
        // loads are ignored while busy; command and address persist
        if (loadStb) begin
          if (action == hvpp_pkg::ACT_CMD) begin
            next_cmd = dataIn;
            if (dataIn == hvpp_pkg::CMD_NOP)
              next_pageValid = '0;
          end else if (action == hvpp_pkg::ACT_ADDR) begin
            if (byte_sel_a) next_addrHi = dataIn;
            else next_addrLo = dataIn;
          end else if (action == hvpp_pkg::ACT_DATA) begin
            if (byte_sel_a) next_dataHi = dataIn;
            else next_dataLo = dataIn;
          end
        end
        // a write strobe is dropped while latched words are still on the way to the buffer
        if (writeStb && !fifoOutValid) begin
          next_count = '0;
          if (isCmd(cmd, hvpp_pkg::CMD_ERASE)) begin
            next_state = HV_ERASE;
            if (!keep_eeprom_on_erase) next_eeErased = 1'b1;
          end else if (isCmd(cmd, hvpp_pkg::CMD_WR_FLASH)) begin
            next_state = HV_PROG;
          end
        end
      end
      HV_ERASE: begin
        // flash first, one word per cycle, then the timed remainder
        next_count = count + CW'(1);
        if (count == CW'(WORDS + ERASE_CYC - 1)) begin
          next_state = HV_LOCKS;
        end
      end
      HV_LOCKS: begin
        next_locks = 1'b1;
        next_state = HV_IDLE;
      end
      HV_PROG: begin
        // commit only latched words; the rest of the page keeps its contents
        next_count = count + CW'(1);
        if (count == CW'(PWORDS + PROG_CYC - 1)) begin
          next_state     = HV_IDLE;
          next_pageValid = '0;
        end
      end
      default: next_state = HV_OFF;
    endcase
    // a word leaving the FIFO wins over a same-cycle clear of the valid bits
    if (fifoDrain) begin
      next_pageValid[fifoOut[FW-1:16]] = 1'b1;
    end
    if (!hvActive) next_state = HV_OFF;
  end

  // ready/busy and bus drive
  // output enable is seen through the synchroniser, so the bus turns a few clocks late
  always_comb begin
    next_rdy     = (next_state == HV_IDLE) || (next_state == HV_OFF) || (next_state == HV_ENTRY);
    next_dataOe  = (next_state != HV_OFF) && (next_state != HV_ENTRY) && !sLevel[3];
    next_dataOut = 8'hff;
    if (isCmd(cmd, hvpp_pkg::CMD_RD_FLASH)) begin
      next_dataOut = byte_sel_a ? flash[wordAddr][15:8] : flash[wordAddr][7:0];
    end else if (isCmd(cmd, hvpp_pkg::CMD_RD_FUSE)) begin
      next_dataOut = {6'h00, byte_sel_b, byte_sel_a};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state          <= HV_OFF;
      cmd            <= hvpp_pkg::RST_CMD;
      addrLo         <= 8'h00;
      addrHi         <= 8'h00;
      dataLo         <= 8'hff;
      dataHi         <= 8'hff;
      count          <= '0;
      pageValid      <= '0;
      ready_busy_out <= 1'b1;
      dataOe         <= 1'b0;
      dataOut        <= 8'h00;
      eepromErased   <= 1'b0;
      locksCleared   <= 1'b0;
      progMode       <= 1'b0;
    end else begin
      state          <= next_state;
      cmd            <= next_cmd;
      addrLo         <= next_addrLo;
      addrHi         <= next_addrHi;
      dataLo         <= next_dataLo;
      dataHi         <= next_dataHi;
      count          <= next_count;
      pageValid      <= next_pageValid;
      ready_busy_out <= next_rdy;
      dataOe         <= next_dataOe;
      dataOut        <= next_dataOut;
      eepromErased   <= next_eeErased;
      locksCleared   <= next_locks;
      progMode       <= (next_state != HV_OFF) && (next_state != HV_ENTRY);
    end
  end

  // arrays: page buffer fill, erase sweep and page commit
  always_ff @(posedge core_clk) begin
    if (fifoDrain) begin
      pageBuf[fifoOut[FW-1:16]] <= fifoOut[15:0];
    end
    if (state == HV_ERASE && count < CW'(WORDS)) begin
      flash[count[ADDR_BITS-1:0]] <= {2{hvpp_pkg::ERASED_BYTE}};
    end
    if (state == HV_PROG && count < CW'(PWORDS) && pageValid[count[PAGE_BITS-1:0]]) begin
      flash[{pageSel, count[PAGE_BITS-1:0]}] <= pageBuf[count[PAGE_BITS-1:0]];
    end
  end

endmodule : hvpp_port

// File: hvpp_port_chk.sv
// hvpp_port_chk: pin-level timing and status assertions for the port
// assumes binding to hvpp_port; one clock, async active-low reset
`timescale 1ns/10ps
module hvpp_port_chk #(
  parameter int ENTRY_CYC = 4,
  parameter int BUSY_MAX  = 3000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // programmer side
  input wire logic hvActive,
  input wire logic keep_eeprom_on_erase,
  input wire logic writeStrobeN,
  input wire logic outEnableN,
  // device side
  input wire logic dataOe,
  input wire logic ready_busy_out,
  input wire logic progMode,
  input wire logic eepromErased,
  input wire logic locksCleared
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  logic [11:0] busyCount;
  logic [11:0] next_busyCount;

  // busy length; no saturation needed since the bound trips long before wrap
  always_comb begin
    next_busyCount = ready_busy_out ? 12'h000 : busyCount + 12'h001;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busyCount <= 12'h000;
    end else begin
      busyCount <= next_busyCount;
    end
  end

  rst_idle_a: assert property ($rose(resetn) |-> ready_busy_out && !progMode && !dataOe)
    else $error("port not idle after reset");
  busy_cause_a: assert property ($fell(ready_busy_out) |-> !$past(writeStrobeN, 3))
    else $error("busy without a write pulse");
  busy_bound_a: assert property (busyCount <= BUSY_MAX)
    else $error("busy far too long");
  oe_drive_a: assert property ((progMode && !outEnableN)[*4] |-> dataOe)
    else $error("bus not driven while output enabled");
  oe_release_a: assert property (outEnableN[*4] |-> !dataOe)
    else $error("bus driven while output disabled");
  mode_exit_a: assert property ($fell(hvActive) |-> ##[0:4] !progMode)
    else $error("mode kept after high voltage removed");
  mode_entry_a: assert property ($rose(progMode) |-> $past(hvActive, ENTRY_CYC + 1))
    else $error("mode entered too early");
  erase_keep_a: assert property ($rose(eepromErased) |->
    !keep_eeprom_on_erase && (!ready_busy_out || !$past(ready_busy_out)))
    else $error("eeprom erased while kept or outside erase");
  locks_end_a: assert property ($rose(locksCleared) |->
    !ready_busy_out || !$past(ready_busy_out) || !$past(ready_busy_out, 2))
    else $error("locks cleared outside erase end");
endmodule : hvpp_port_chk

bind hvpp_port hvpp_port_chk #(.ENTRY_CYC(ENTRY_CYC)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .hvActive(hvActive),
  .keep_eeprom_on_erase(keep_eeprom_on_erase), .writeStrobeN(writeStrobeN),
  .outEnableN(outEnableN), .dataOe(dataOe), .ready_busy_out(ready_busy_out),
  .progMode(progMode), .eepromErased(eepromErased), .locksCleared(locksCleared)
);

// File: hvpp_prog_model.sv
// hvpp_prog_model: behavioural parallel programmer driving the port pins
// assumes one task at a time; pins change just after a rising edge
`timescale 1ns/10ps
module hvpp_prog_model #(
  parameter int PW       = 14,
  parameter int HOLD_CYC = 500,
  parameter int WAIT_CYC = 15000
) (
  // clock and device answers
  input  wire logic       core_clk,
  input  wire logic       ready_busy_out,
  input  wire logic       dataOe,
  input  wire logic [7:0] busLevel,
  // pins toward the device
  output logic            hvActive,
  output logic            load_strobe,
  output logic            buffer_latch_strobe,
  output logic            writeStrobeN,
  output logic            outEnableN,
  output logic            action_code_bit0,
  output logic            action_code_bit1,
  output logic            byte_sel_a,
  output logic            byte_sel_b,
  output logic [7:0]      busDrv
);
  // idle pins; entry pattern is all low from the start
  initial begin
    {hvActive, load_strobe, buffer_latch_strobe, action_code_bit1} = 4'h0;
    {action_code_bit0, byte_sel_a, byte_sel_b} = 3'h0;
    {writeStrobeN, outEnableN} = 2'h3;
    busDrv = 8'h00;
  end

  // released bus toggles so a stale value never passes for read data
  always @(posedge core_clk) if (!outEnableN) busDrv <= ~busDrv;

  task automatic waitCyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : waitCyc

  task automatic enter;
    @(posedge core_clk);
    hvActive <= 1'b1;
    waitCyc(HOLD_CYC);
    waitCyc(WAIT_CYC);
  endtask : enter

  task automatic leave;
    @(posedge core_clk);
    hvActive <= 1'b0;
    waitCyc(PW);
  endtask : leave

  task automatic load(input logic [1:0] act, input logic bsa, input logic [7:0] val);
    @(posedge core_clk);
    {action_code_bit1, action_code_bit0} <= act;
    byte_sel_a <= bsa;
    busDrv <= val;
    waitCyc(1);
    load_strobe <= 1'b1;
    waitCyc(PW);
    load_strobe <= 1'b0;
    waitCyc(PW);
  endtask : load

  task automatic latch(input logic bsa);
    @(posedge core_clk);
    byte_sel_a <= bsa;
    waitCyc(1);
    buffer_latch_strobe <= 1'b1;
    waitCyc(PW);
    buffer_latch_strobe <= 1'b0;
    waitCyc(PW);
  endtask : latch

  task automatic wrPulse(output logic ok);
    logic busy;
    int n;
    busy = 1'b0;
    @(posedge core_clk);
    writeStrobeN <= 1'b0;
    repeat (PW) begin
      @(posedge core_clk);
      busy |= !ready_busy_out;
    end
    writeStrobeN <= 1'b1;
    for (n = 0; n < 5000 && !ready_busy_out; n++) @(posedge core_clk);
    ok = busy && ready_busy_out;
    waitCyc(PW);
  endtask : wrPulse

  task automatic rdWord(input logic bsb, output logic [15:0] v, output logic oe);
    @(posedge core_clk);
    byte_sel_a <= 1'b0;
    byte_sel_b <= bsb;
    outEnableN <= 1'b0;
    waitCyc(PW);
    @(negedge core_clk);
    v[7:0] = busLevel;
    oe = dataOe;
    @(posedge core_clk);
    byte_sel_a <= 1'b1;
    waitCyc(PW);
    @(negedge core_clk);
    v[15:8] = busLevel;
    @(posedge core_clk);
    outEnableN <= 1'b1;
    waitCyc(PW);
  endtask : rdWord
endmodule : hvpp_prog_model

// File: hvpp_sync.sv
// hvpp_sync: two-flop synchroniser with edge detection, one per strobe
// assumes strobe inputs are asynchronous levels from the programmer pins
`timescale 1ns/10ps
module hvpp_sync #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // raw and clean levels
  input  wire logic [N-1:0] rawIn,
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  logic [N-1:0] stage1;
  logic [N-1:0] stage2;
  logic [N-1:0] stage3;
  logic [N-1:0] next_stage1;
  logic [N-1:0] next_stage2;
  logic [N-1:0] next_stage3;

  // stage1 is read only by stage2; edges come from stage2 versus stage3
  always_comb begin
    next_stage1 = rawIn;
    next_stage2 = stage1;
    next_stage3 = stage2;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
    end
  end

  // one pulse per clean edge; shorter glitches never reach stage2 twice
  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;

endmodule : hvpp_sync

// File: tb_hvpp_port.sv
// tb_hvpp_port: self-checking bench with an associative-array model of flash pages
// assumes hvpp_prog_model drives the pins; page size 32 words
`timescale 1ns/10ps
module tb_hvpp_port;
  logic        core_clk, resetn, keepEeprom, hvActive, loadStb, latchStb;
  logic        writeN, oeN, act0, act1, bsa, bsb, dataOe, rdy, progMode;
  logic        eeErased, locksClr, ok;
  logic [7:0]  busDrv, busLevel, dataOut;
  logic [31:0] lfsr;
  logic [15:0] dat, v;
  logic [5:0]  pg, pgs [2];
  int          failCount, numChecks, key, k, p, i, w, b, idx;
  int          flashMod [int];
  int          bufIdx [$], bufDat [$];
  logic [7:0]  cmds [6] = '{hvpp_pkg::CMD_WR_FUSE, hvpp_pkg::CMD_WR_LOCK,
    hvpp_pkg::CMD_WR_EEPROM, hvpp_pkg::CMD_RD_SIG, hvpp_pkg::CMD_RD_EEPROM, hvpp_pkg::CMD_NOP};

  // the device owns the wire only while it enables its driver
  assign busLevel = dataOe ? dataOut : busDrv;

  hvpp_port #(.ENTRY_CYC(4)) u_hvpp_port (
    .core_clk(core_clk), .resetn(resetn), .hvActive(hvActive),
    .keep_eeprom_on_erase(keepEeprom), .load_strobe(loadStb),
    .buffer_latch_strobe(latchStb), .writeStrobeN(writeN), .outEnableN(oeN),
    .action_code_bit0(act0), .action_code_bit1(act1), .byte_sel_a(bsa),
    .byte_sel_b(bsb), .dataIn(busLevel), .dataOut(dataOut), .dataOe(dataOe),
    .ready_busy_out(rdy), .progMode(progMode), .eepromErased(eeErased),
    .locksCleared(locksClr));
  hvpp_prog_model u_hvpp_prog_model (
    .core_clk(core_clk), .ready_busy_out(rdy), .dataOe(dataOe), .busLevel(busLevel),
    .hvActive(hvActive), .load_strobe(loadStb), .buffer_latch_strobe(latchStb),
    .writeStrobeN(writeN), .outEnableN(oeN), .action_code_bit0(act0),
    .action_code_bit1(act1), .byte_sel_a(bsa), .byte_sel_b(bsb), .busDrv(busDrv));

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsrNext

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // watchdog sized well above the roughly 30k cycles the sequence needs
  initial begin
    repeat (90000) @(posedge core_clk);
    failCount++;
    summarize();
  end

  // main sequence: reset, entry, erase, page writes, reads, exit
  initial begin
    resetn = 1'b0;
    keepEeprom = 1'b1;
    lfsr = 32'h75ed;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    check(rdy, 16'h0001, "ready after reset");
    check(progMode, 16'h0000, "mode after reset");
    u_hvpp_prog_model.enter();
    @(negedge core_clk);
    check(progMode, 16'h0001, "mode entered");
    for (k = 1; k >= 0; k--) begin
      @(posedge core_clk);
      keepEeprom <= k[0];
      u_hvpp_prog_model.load(hvpp_pkg::ACT_CMD, 1'b0, hvpp_pkg::CMD_ERASE);
      u_hvpp_prog_model.wrPulse(ok);
      @(negedge core_clk);
      check(ok, 16'h0001, "erase busy then ready");
      check(eeErased, !k[0], "eeprom erase flag");
      check(locksClr, 16'h0001, "locks cleared");
    end
    foreach (cmds[c]) u_hvpp_prog_model.load(hvpp_pkg::ACT_CMD, 1'b0, cmds[c]);
    @(negedge core_clk);
    check(rdy, 16'h0001, "loads alone stay ready");
    lfsr = lfsrNext(lfsr);
    pgs[0] = lfsr[5:0];
    pgs[1] = lfsr[5:0] ^ 6'h2b;
    for (p = 0; p < 2; p++) begin
      pg = pgs[p];
      bufIdx.delete();
      bufDat.delete();
      u_hvpp_prog_model.load(hvpp_pkg::ACT_CMD, 1'b0, hvpp_pkg::CMD_WR_FLASH);
      for (i = 0; i < (p ? 4 : 32); i++) begin
        idx = p ? (i * 7 + 3) % 32 : i;
        lfsr = lfsrNext(lfsr);
        dat = lfsr[15:0];
        u_hvpp_prog_model.load(hvpp_pkg::ACT_ADDR, 1'b0, {pg[2:0], idx[4:0]});
        u_hvpp_prog_model.load(hvpp_pkg::ACT_DATA, 1'b0, dat[7:0]);
        u_hvpp_prog_model.load(hvpp_pkg::ACT_DATA, 1'b1, dat[15:8]);
        u_hvpp_prog_model.latch(!(p == 1 && i == 0));
        if (!(p == 1 && i == 0)) bufIdx.push_back(idx);
        if (!(p == 1 && i == 0)) bufDat.push_back(int'(dat));
      end
      u_hvpp_prog_model.load(hvpp_pkg::ACT_ADDR, 1'b1, {5'h00, pg[5:3]});
      u_hvpp_prog_model.wrPulse(ok);
      check(ok, 16'h0001, "page program busy then ready");
      foreach (bufIdx[j]) flashMod[int'(pg) * 32 + bufIdx[j]] = bufDat[j];
      u_hvpp_prog_model.load(hvpp_pkg::ACT_CMD, 1'b0, hvpp_pkg::CMD_NOP);
    end
    u_hvpp_prog_model.load(hvpp_pkg::ACT_CMD, 1'b0, hvpp_pkg::CMD_RD_FLASH);
    for (p = 0; p < 2; p++) begin
      pg = pgs[p];
      u_hvpp_prog_model.load(hvpp_pkg::ACT_ADDR, 1'b1, {5'h00, pg[5:3]});
      for (w = 0; w < 32; w++) begin
        key = int'(pg) * 32 + w;
        u_hvpp_prog_model.load(hvpp_pkg::ACT_ADDR, 1'b0, {pg[2:0], w[4:0]});
        if (w == 0) u_hvpp_prog_model.load(hvpp_pkg::ACT_IDLE, 1'b0, 8'h5a);
        u_hvpp_prog_model.rdWord(1'b0, v, ok);
        check(v, flashMod.exists(key) ? flashMod[key][15:0] : 16'hffff, "flash word");
        check(ok, 16'h0001, "bus driven on read");
        @(negedge core_clk);
        check(dataOe, 16'h0000, "bus released");
      end
    end
    u_hvpp_prog_model.load(hvpp_pkg::ACT_CMD, 1'b0, hvpp_pkg::CMD_RD_FUSE);
    for (b = 0; b < 2; b++) begin
      u_hvpp_prog_model.rdWord(b[0], v, ok);
      check(v, {6'h00, b[0], 1'b1, 6'h00, b[0], 1'b0}, "fuse byte select");
    end
    u_hvpp_prog_model.leave();
    @(negedge core_clk);
    check(progMode, 16'h0000, "mode left");
    summarize();
  end
endmodule : tb_hvpp_port
